// ---- dv/lpw_ctrl_monitor.sv ----
// Concurrent checks on the low-power wake controller ports
module lpw_ctrl_monitor
    import lpw_pkg::*;
#(
    parameter int unsigned FULL_RECOVERY = LPW_RECOVERY_FULL,
    parameter int unsigned SHORT_RECOVERY = LPW_RECOVERY_SHORT,
    parameter int unsigned KEY_PINS = LPW_KEY_PINS
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire lpw_cfg_s cfg,
    input wire logic stop_instr,
    input wire logic osc_ref_tick,
    input wire logic rst_pin_n,
    input wire logic watchdog_timeout,
    input wire logic brownout_trip,
    input wire logic ext_irq_pin,
    input wire logic ext_irq_request_mask,
    input wire logic [KEY_PINS-1:0] key_pins,
    input wire lpw_req_s periph_req,
    input wire logic serial_busy,
    input wire lpw_state_e mode,
    input wire lpw_clk_s clk_ctrl,
    input wire lpw_act_s act,
    input wire logic watchdog_count_clear,
    input wire logic mcu_reset,
    input wire logic spi_reset,
    input wire logic serial_data_invalid,
    input wire logic vector_fetch,
    input wire logic [15:0] vector_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    int unsigned ticks;
    logic quiet;

    // Reference ticks seen during one recovery; cleared in every other state
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ticks <= 0;
        end else if (mode != LPW_RECOVER) begin
            ticks <= 0;
        end else if (osc_ref_tick) begin
            ticks <= ticks + 1;
        end
    end

    // No reset source asserted this cycle
    assign quiet = rst_pin_n && !watchdog_timeout && !brownout_trip;

    chk_stop_refused: assert property (mode == LPW_RUN && stop_instr && !cfg.stop_enable
        |=> mode != LPW_STOP && !watchdog_count_clear) else $error("stop taken while disabled");
    chk_stop_entry: assert property (mode == LPW_RUN && stop_instr && cfg.stop_enable && quiet
        |=> mode == LPW_STOP && watchdog_count_clear && serial_data_invalid == $past(serial_busy))
        else $error("stop entry effects wrong");
    chk_wait_clocks: assert property (mode == LPW_WAIT |-> !clk_ctrl.cpu_clk_en
        && clk_ctrl.bus_clk_en && clk_ctrl.watchdog_clk_en && act.tick_active && !act.tick_reg_access
        && act.timer_active && act.spi_active && act.serial_active
        && act.brownout_active == cfg.brownout_enable) else $error("wait gating wrong");
    chk_stop_clocks: assert property (mode == LPW_STOP |-> !clk_ctrl.cpu_clk_en
        && !clk_ctrl.watchdog_clk_en && !clk_ctrl.loop_enable && !act.tick_reg_access
        && clk_ctrl.osc_enable == cfg.osc_on_in_stop && act.tick_active == cfg.osc_on_in_stop
        && !act.serial_active && !act.spi_active && !act.timer_active && !clk_ctrl.bus_clk_en
        && clk_ctrl.clock_gen_out_en == cfg.osc_on_in_stop
        && act.brownout_active == (cfg.brownout_enable && cfg.brownout_stop_enable))
        else $error("stop gating wrong");
    chk_wait_wake: assert property (mode == LPW_WAIT && periph_req != '0 && quiet
        |=> mode == LPW_FETCH) else $error("wait not ended by request");
    chk_stop_holds: assert property (mode == LPW_STOP && quiet && !periph_req.brk
        && !periph_req.tick && $stable(ext_irq_pin) && $stable(key_pins) |=> mode == LPW_STOP)
        else $error("stop left without a wake event");
    chk_irq_exit: assert property (mode == LPW_STOP && $fell(ext_irq_pin) && !ext_irq_request_mask
        |=> mode == LPW_RECOVER) else $error("irq edge did not start recovery");
    chk_reset_exit: assert property (mode == LPW_STOP && !rst_pin_n
        |=> mcu_reset && spi_reset && mode == LPW_RECOVER) else $error("reset exit wrong");
    chk_recovery_len: assert property (mode == LPW_FETCH && $past(mode) == LPW_RECOVER
        |-> ticks == (cfg.short_recovery_select ? SHORT_RECOVERY : FULL_RECOVERY))
        else $error("recovery length wrong");
    chk_fetch_pulse: assert property (mode == LPW_FETCH && $past(mode) != LPW_FETCH
        |-> ##2 vector_fetch && mode == LPW_RUN) else $error("vector fetch late");

    cover property (mode == LPW_WAIT ##1 mode == LPW_FETCH);
    cover property (mode == LPW_STOP ##1 mode == LPW_RECOVER);
    cover property (vector_fetch && vector_addr == 16'hFFFE);
endmodule

bind lpw_ctrl lpw_ctrl_monitor #(
    .FULL_RECOVERY(FULL_RECOVERY),
    .SHORT_RECOVERY(SHORT_RECOVERY),
    .KEY_PINS(KEY_PINS)
) i_mon (.sys_clk, .resetn, .cfg, .stop_instr, .osc_ref_tick, .rst_pin_n, .watchdog_timeout,
    .brownout_trip, .ext_irq_pin, .ext_irq_request_mask, .key_pins, .periph_req, .serial_busy,
    .mode, .clk_ctrl, .act, .watchdog_count_clear, .mcu_reset, .spi_reset, .serial_data_invalid,
    .vector_fetch, .vector_addr);

// ---- dv/lpw_osc_model.sv ----
// Oscillator reference tick source standing beside the controller
module lpw_osc_model #(
    parameter int PERIOD = 3
)
(
    input wire logic sys_clk,
    input wire logic osc_enable,
    output logic osc_ref_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    int phase = 0;
    initial osc_ref_tick = 1'b0;
    // no ticks while off
    // A stopped oscillator gives no ticks, so stop timing cannot lean on a free run
    always @(negedge sys_clk) begin
        phase = osc_enable ? (phase + 1) % PERIOD : 0;
        osc_ref_tick <= osc_enable && phase == PERIOD - 1;
    end
endmodule

// ---- dv/test_low_power_wake_control.sv ----
// Self-checking bench for the low-power wake controller
module test_low_power_wake_control
    import lpw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, resetn = 1'b0, wait_instr = 1'b0, stop_instr = 1'b0, rst_pin_n = 1'b1;
    logic watchdog_timeout = 1'b0, brownout_trip = 1'b0, ext_irq_pin = 1'b1, serial_busy = 1'b0;
    logic ext_irq_request = 1'b0, ext_irq_request_mask = 1'b1, key_request = 1'b0;
    logic key_request_mask = 1'b1;
    logic [7:0] key_pins = 8'h00, key_polarity_bits = 8'h00;
    lpw_cfg_s cfg = '0;
    lpw_req_s periph_req = '0;
    logic osc_ref_tick, watchdog_count_clear, mcu_reset, spi_reset, serial_data_invalid;
    logic vector_fetch;
    logic [15:0] vector_addr;
    lpw_state_e mode;
    lpw_clk_s clk_ctrl;
    lpw_act_s act;
    int errors = 0, compares = 0, cycles = 0;
    // Expected vector per request bit, brk first, first timer overflow last
    logic [15:0] vt [19] = '{16'hFFFC, 16'hFFF8, 16'hFFDC, 16'hFFDE, 16'hFFE6, 16'hFFE4,
        16'hFFE2, 16'hFFEA, 16'hFFE8, 16'hFFF0, 16'hFFEE, 16'hFFEC, 16'hFFD2, 16'hFFD0,
        16'hFFCE, 16'hFFCC, 16'hFFF6, 16'hFFF4, 16'hFFF2};

    always #5 sys_clk = ~sys_clk;

    lpw_ctrl #(.FULL_RECOVERY(8)) i_dut (.sys_clk, .resetn, .cfg, .wait_instr, .stop_instr,
        .osc_ref_tick, .rst_pin_n, .watchdog_timeout, .brownout_trip, .ext_irq_pin,
        .ext_irq_request, .ext_irq_request_mask, .key_pins, .key_enable(8'hFF),
        .key_polarity_bits, .key_request, .key_request_mask, .periph_req, .serial_busy, .mode,
        .clk_ctrl, .act, .watchdog_count_clear, .mcu_reset, .spi_reset, .serial_data_invalid,
        .vector_fetch, .vector_addr);

    lpw_osc_model #(.PERIOD(3)) i_osc (.sys_clk, .osc_enable(clk_ctrl.osc_enable),
        .osc_ref_tick);

    task test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Cut a hung run short well past the longest expected sequence
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end

    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle instruction pulse, then the mode it leaves behind
    task doze(input bit stop, input lpw_state_e exp);
        @(negedge sys_clk);
        stop_instr = stop;
        wait_instr = !stop;
        @(negedge sys_clk);
        stop_instr = 1'b0;
        wait_instr = 1'b0;
        check("mode", 16'(mode), 16'(exp));
    endtask

    // Bounded wait for the fetch, then every wake source goes idle again
    task wake(input logic [15:0] exp);
        for (int n = 0; n < 300 && vector_fetch !== 1'b1; n++) @(negedge sys_clk);
        check("fetch", {15'h0000, vector_fetch}, 16'h0001);
        check("vector", vector_addr, exp);
        periph_req = '0;
        rst_pin_n = 1'b1;
        watchdog_timeout = 1'b0;
        brownout_trip = 1'b0;
        ext_irq_pin = 1'b1;
        ext_irq_request = 1'b0;
        key_request = 1'b0;
        key_pins = 8'h00;
        serial_busy = 1'b0;
        repeat (3) @(negedge sys_clk);
        check("mode", 16'(mode), 16'(LPW_RUN));
    endtask

    initial begin
        cfg.watchdog_enable = 1'b1;
        repeat (12) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < 19; i++) begin
            doze(1'b0, LPW_WAIT);
            periph_req = lpw_req_s'(19'h00001 << i);
            wake(vt[i]);
        end
        doze(1'b0, LPW_WAIT);
        ext_irq_request = 1'b1;
        key_request = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("mode", 16'(mode), 16'(LPW_WAIT));
        ext_irq_request_mask = 1'b0;
        wake(16'hFFFA);
        key_request_mask = 1'b0;
        doze(1'b0, LPW_WAIT);
        key_request = 1'b1;
        wake(16'hFFE0);
        doze(1'b0, LPW_WAIT);
        watchdog_timeout = 1'b1;
        wake(16'hFFFE);
        cfg.brownout_enable = 1'b1;
        cfg.brownout_rst_enable = 1'b1;
        doze(1'b0, LPW_WAIT);
        brownout_trip = 1'b1;
        wake(16'hFFFE);
        doze(1'b1, LPW_RUN);
        cfg.stop_enable = 1'b1;
        serial_busy = 1'b1;
        doze(1'b1, LPW_STOP);
        periph_req.timer1 = 3'h4;
        periph_req.spi = 2'h1;
        repeat (4) @(negedge sys_clk);
        check("mode", 16'(mode), 16'(LPW_STOP));
        ext_irq_pin = 1'b0;
        wake(16'hFFFA);
        doze(1'b1, LPW_STOP);
        rst_pin_n = 1'b0;
        wake(16'hFFFE);
        cfg.brownout_stop_enable = 1'b1;
        doze(1'b1, LPW_STOP);
        brownout_trip = 1'b1;
        wake(16'hFFFE);
        key_polarity_bits = 8'h01;
        doze(1'b1, LPW_STOP);
        key_pins = 8'h01;
        wake(16'hFFE0);
        doze(1'b1, LPW_STOP);
        periph_req.brk = 1'b1;
        wake(16'hFFFC);
        // short delay only with oscillator kept running
        cfg.osc_on_in_stop = 1'b1;
        cfg.short_recovery_select = 1'b1;
        doze(1'b1, LPW_STOP);
        periph_req.tick = 1'b1;
        wake(16'hFFDC);
        test_done();
    end
endmodule

// ---- rtl/lpw_ctrl.sv ----
// Low-power mode controller: wait/stop entry, wake, recovery and vector select
// Operation
// - Watchdog runs in wait, resets on timeout
// - Stop gates watchdog clock, clears its counter
// - Stop instruction ignored unless stop enabled
// - Unmasked external interrupt ends wait and stop
// - Unmasked key request ends wait and stop
// - Enabled brownout reset ends wait and stop
// - Serial, SPI, timer requests end wait
// - Serial idle in stop; transfer data invalid
// - SPI idle in stop; reset exit resets it
// - Timers frozen in stop, resume on interrupt
// - Tick runs in wait; register locked
// - Tick runs in stop only with oscillator
// - Resets restart clocks, fetch reset vector
// - Irq, break, clock interrupt use own vectors
// - Only listed events end stop mode
// - Recovery holds clocks 4096 reference cycles
// - Short recovery select gives 32 cycles
// - Wait stops CPU clock, bus runs
// - Stop gates loop; oscillator per config
module lpw_ctrl
    import lpw_pkg::*;
#(
    parameter int unsigned FULL_RECOVERY = LPW_RECOVERY_FULL,
    parameter int unsigned SHORT_RECOVERY = LPW_RECOVERY_SHORT,
    parameter int unsigned KEY_PINS = LPW_KEY_PINS
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire lpw_cfg_s cfg,
    input wire logic wait_instr,
    input wire logic stop_instr,
    input wire logic osc_ref_tick,
    input wire logic rst_pin_n,
    input wire logic watchdog_timeout,
    input wire logic brownout_trip,
    input wire logic ext_irq_pin,
    input wire logic ext_irq_request,
    input wire logic ext_irq_request_mask,
    input wire logic [KEY_PINS-1:0] key_pins,
    input wire logic [KEY_PINS-1:0] key_enable,
    input wire logic [KEY_PINS-1:0] key_polarity_bits,
    input wire logic key_request,
    input wire logic key_request_mask,
    input wire lpw_req_s periph_req,
    input wire logic serial_busy,
    output lpw_state_e mode,
    output lpw_clk_s clk_ctrl,
    output lpw_act_s act,
    output logic watchdog_count_clear,
    output logic mcu_reset,
    output logic spi_reset,
    output logic serial_data_invalid,
    output logic vector_fetch,
    output logic [15:0] vector_addr
);

    localparam logic [LPW_RECOVERY_BITS-1:0] FULL_LAST =
        LPW_RECOVERY_BITS'(FULL_RECOVERY - 1);
    localparam logic [LPW_RECOVERY_BITS-1:0] SHORT_LAST =
        LPW_RECOVERY_BITS'(SHORT_RECOVERY - 1);

    // All controller state in one record
    typedef struct packed {
        lpw_state_e state;
        lpw_src_e src;
        logic [LPW_RECOVERY_BITS-1:0] rec_cnt;
        logic fetch_phase;
        logic irq_prev;
        logic [KEY_PINS-1:0] key_prev;
        lpw_clk_s clk;
        lpw_act_s act;
        logic watchdog_count_clear;
        logic mcu_reset;
        logic spi_reset;
        logic serial_data_invalid;
        logic vector_fetch;
        logic [15:0] vector_addr;
    } lpw_ctrl_s;

    localparam lpw_clk_s CLK_RUN = '{cpu_clk_en: 1'b1, bus_clk_en: 1'b1, osc_enable: 1'b1,
        loop_enable: 1'b1, clock_gen_out_en: 1'b1, watchdog_clk_en: 1'b1};
    localparam lpw_act_s ACT_RUN = '{serial_active: 1'b1, spi_active: 1'b1,
        timer_active: 1'b1, tick_active: 1'b1, tick_reg_access: 1'b1,
        brownout_active: 1'b1};

    logic [1:0] rst_sync;
    logic rst_n;
    lpw_ctrl_s st;
    lpw_ctrl_s next_st;
    logic [15:0] rom_addr;
    logic [KEY_PINS-1:0] key_edge;
    logic [LPW_SRC_COUNT-1:0] req_all;
    logic [LPW_SRC_COUNT-1:0] wake_wait;
    logic [LPW_SRC_COUNT-1:0] wake_stop;
    logic brownout_live;
    logic watchdog_live;
    logic reset_event;
    logic rec_done;

    // Lowest set index wins; used for both wait and stop wake words
    function automatic lpw_src_e lpw_pick(input logic [LPW_SRC_COUNT-1:0] w);
        lpw_pick = LPW_SRC_RESET;
        for (int i = LPW_SRC_COUNT - 1; i >= 0; i--) begin
            if (w[i]) begin
                lpw_pick = lpw_src_e'(LPW_SRC_BITS'(i));
            end
        end
    endfunction

    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Key pin edges, direction chosen by the polarity bits
    // key edge polarity
    generate
        for (genvar k = 0; k < KEY_PINS; k++) begin : g_key
            assign key_edge[k] = key_enable[k] & (key_polarity_bits[k] ?
                (key_pins[k] & ~st.key_prev[k]) : (~key_pins[k] & st.key_prev[k]));
        end
    endgenerate

    // Brownout and watchdog liveness per mode
    // brownout in stop
    assign brownout_live = cfg.brownout_enable &
        ((st.state != LPW_STOP) | cfg.brownout_stop_enable);
    assign watchdog_live = cfg.watchdog_enable & st.clk.watchdog_clk_en;
    assign reset_event = ~rst_pin_n | (watchdog_live & watchdog_timeout) |
        (brownout_live & cfg.brownout_rst_enable & brownout_trip);

    // Request word in source order; reset and key/irq slots filled per mode
    // first timer vectors
    assign req_all = {periph_req.timer2[6:3], periph_req.tick, periph_req.adc, 1'b0,
        periph_req.serial, periph_req.spi, periph_req.timer2[2:0], periph_req.timer1,
        periph_req.clock_gen, 1'b0, periph_req.brk, reset_event};

    // Wait ends on any enabled request
    // irq ends wait
    always_comb begin
        wake_wait = req_all;
        wake_wait[LPW_SRC_EXT_IRQ] = ext_irq_request & ~ext_irq_request_mask;
        wake_wait[LPW_SRC_KEY] = key_request & ~key_request_mask;
    end

    // Stop ends only on the short list
    // stop exit events
    always_comb begin
        wake_stop = '0;
        wake_stop[LPW_SRC_RESET] = reset_event;
        wake_stop[LPW_SRC_BREAK] = periph_req.brk;
        wake_stop[LPW_SRC_EXT_IRQ] = ~ext_irq_pin & st.irq_prev & ~ext_irq_request_mask;
        wake_stop[LPW_SRC_KEY] = (|key_edge) & ~key_request_mask;
        wake_stop[LPW_SRC_TICK] = periph_req.tick & cfg.osc_on_in_stop;
    end

    // Recovery ends on the last reference tick of the selected length
    // full recovery count
    assign rec_done = osc_ref_tick &
        (st.rec_cnt == (cfg.short_recovery_select ? SHORT_LAST : FULL_LAST));

    // Next state and registered outputs
    always_comb begin
        next_st = st;
        next_st.irq_prev = ext_irq_pin;
        next_st.key_prev = key_pins;
        next_st.watchdog_count_clear = 1'b0;
        next_st.mcu_reset = 1'b0;
        next_st.spi_reset = 1'b0;
        next_st.serial_data_invalid = 1'b0;
        next_st.vector_fetch = 1'b0;
        next_st.clk = CLK_RUN;
        next_st.act = ACT_RUN;
        unique case (st.state)
            LPW_RUN: begin
                if (reset_event) begin
                    next_st.mcu_reset = 1'b1;
                    next_st.src = LPW_SRC_RESET;
                    next_st.fetch_phase = 1'b0;
                    next_st.state = LPW_FETCH;
                end else if (stop_instr && cfg.stop_enable) begin
                    next_st.state = LPW_STOP;
                    next_st.watchdog_count_clear = 1'b1;
                    next_st.serial_data_invalid = serial_busy;
                end else if (wait_instr) begin
                    next_st.state = LPW_WAIT;
                end
            end
            LPW_WAIT: begin
                if (|wake_wait) begin
                    next_st.src = lpw_pick(wake_wait);
                    next_st.mcu_reset = reset_event;
                    next_st.fetch_phase = 1'b0;
                    next_st.state = LPW_FETCH;
                end
            end
            LPW_STOP: begin
                if (|wake_stop) begin
                    next_st.src = lpw_pick(wake_stop);
                    next_st.mcu_reset = reset_event;
                    next_st.spi_reset = reset_event;
                    next_st.rec_cnt = '0;
                    next_st.state = LPW_RECOVER;
                end
            end
            LPW_RECOVER: begin
                if (rec_done) begin
                    next_st.fetch_phase = 1'b0;
                    next_st.state = LPW_FETCH;
                end else if (osc_ref_tick) begin
                    next_st.rec_cnt = st.rec_cnt + 1'b1;
                end
            end
            LPW_FETCH: begin
                // Table read is registered, so the address is taken a cycle later
                next_st.fetch_phase = 1'b1;
                if (st.fetch_phase) begin
                    next_st.vector_fetch = 1'b1;
                    next_st.vector_addr = rom_addr;
                    next_st.state = LPW_RUN;
                end
            end
            default: begin
                next_st.state = LPW_RUN;
            end
        endcase
        // Clock and activity view of the state being entered
        unique case (next_st.state)
            LPW_WAIT: begin
                next_st.clk.cpu_clk_en = 1'b0;
                next_st.act.tick_reg_access = 1'b0;
            end
            LPW_STOP, LPW_RECOVER: begin
                next_st.clk.cpu_clk_en = 1'b0;
                next_st.clk.bus_clk_en = 1'b0;
                next_st.clk.loop_enable = 1'b0;
                next_st.clk.osc_enable = cfg.osc_on_in_stop | (next_st.state == LPW_RECOVER);
                next_st.clk.clock_gen_out_en = cfg.osc_on_in_stop;
                next_st.clk.watchdog_clk_en = 1'b0;
                next_st.act.serial_active = 1'b0;
                next_st.act.spi_active = 1'b0;
                next_st.act.timer_active = 1'b0;
                next_st.act.tick_active = cfg.osc_on_in_stop & (next_st.state == LPW_STOP);
                next_st.act.tick_reg_access = 1'b0;
            end
            default: begin
            end
        endcase
        // brownout view follows the state being entered, not the one left
        next_st.act.brownout_active = cfg.brownout_enable &
            ((next_st.state != LPW_STOP) | cfg.brownout_stop_enable);
    end

    // Vector table
    lpw_vec_rom u_rom (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .src(st.src),
        .vector_addr(rom_addr)
    );

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{state: LPW_RUN, src: LPW_SRC_RESET, rec_cnt: '0, fetch_phase: 1'b0,
                irq_prev: 1'b1, key_prev: '0, clk: CLK_RUN, act: ACT_RUN,
                watchdog_count_clear: 1'b0, mcu_reset: 1'b0, spi_reset: 1'b0,
                serial_data_invalid: 1'b0, vector_fetch: 1'b0, vector_addr: LPW_VEC_RESET};
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state record
    assign mode = st.state;
    assign clk_ctrl = st.clk;
    assign act = st.act;
    assign watchdog_count_clear = st.watchdog_count_clear;
    assign mcu_reset = st.mcu_reset;
    assign spi_reset = st.spi_reset;
    assign serial_data_invalid = st.serial_data_invalid;
    assign vector_fetch = st.vector_fetch;
    assign vector_addr = st.vector_addr;

endmodule

// ---- rtl/lpw_pkg.sv ----
// Shared types and constants for the low-power wake controller
package lpw_pkg;

    // Stop recovery lengths in oscillator reference clock cycles
    localparam int unsigned LPW_RECOVERY_FULL = 4096;
    localparam int unsigned LPW_RECOVERY_SHORT = 32;
    localparam int unsigned LPW_RECOVERY_BITS = 12;

    // Number of wake sources and width of a source index
    localparam int unsigned LPW_SRC_COUNT = 22;
    localparam int unsigned LPW_SRC_BITS = 5;
    localparam int unsigned LPW_KEY_PINS = 8;

    // Vector pair addresses, high byte address of each pair
    localparam logic [15:0] LPW_VEC_RESET = 16'hFFFE;
    localparam logic [15:0] LPW_VEC_BREAK = 16'hFFFC;
    localparam logic [15:0] LPW_VEC_EXT_IRQ = 16'hFFFA;
    localparam logic [15:0] LPW_VEC_CLOCK_GEN = 16'hFFF8;
    localparam logic [15:0] LPW_VEC_T1_CH0 = 16'hFFF6;
    localparam logic [15:0] LPW_VEC_T1_CH1 = 16'hFFF4;
    localparam logic [15:0] LPW_VEC_T1_OVF = 16'hFFF2;
    localparam logic [15:0] LPW_VEC_T2_CH0 = 16'hFFF0;
    localparam logic [15:0] LPW_VEC_T2_CH1 = 16'hFFEE;
    localparam logic [15:0] LPW_VEC_T2_OVF = 16'hFFEC;
    localparam logic [15:0] LPW_VEC_SPI_RX = 16'hFFEA;
    localparam logic [15:0] LPW_VEC_SPI_TX = 16'hFFE8;
    localparam logic [15:0] LPW_VEC_SER_ERR = 16'hFFE6;
    localparam logic [15:0] LPW_VEC_SER_RX = 16'hFFE4;
    localparam logic [15:0] LPW_VEC_SER_TX = 16'hFFE2;
    localparam logic [15:0] LPW_VEC_KEY = 16'hFFE0;
    localparam logic [15:0] LPW_VEC_ADC = 16'hFFDE;
    localparam logic [15:0] LPW_VEC_TICK = 16'hFFDC;
    localparam logic [15:0] LPW_VEC_T2_CH2 = 16'hFFD2;
    localparam logic [15:0] LPW_VEC_T2_CH3 = 16'hFFD0;
    localparam logic [15:0] LPW_VEC_T2_CH4 = 16'hFFCE;
    localparam logic [15:0] LPW_VEC_T2_CH5 = 16'hFFCC;

    // Wake sources, lowest index wins
    typedef enum logic [4:0] {
        LPW_SRC_RESET = 5'h00, LPW_SRC_BREAK = 5'h01, LPW_SRC_EXT_IRQ = 5'h02,
        LPW_SRC_CLOCK_GEN = 5'h03, LPW_SRC_T1_CH0 = 5'h04, LPW_SRC_T1_CH1 = 5'h05,
        LPW_SRC_T1_OVF = 5'h06, LPW_SRC_T2_CH0 = 5'h07, LPW_SRC_T2_CH1 = 5'h08,
        LPW_SRC_T2_OVF = 5'h09, LPW_SRC_SPI_RX = 5'h0A, LPW_SRC_SPI_TX = 5'h0B,
        LPW_SRC_SER_ERR = 5'h0C, LPW_SRC_SER_RX = 5'h0D, LPW_SRC_SER_TX = 5'h0E,
        LPW_SRC_KEY = 5'h0F, LPW_SRC_ADC = 5'h10, LPW_SRC_TICK = 5'h11,
        LPW_SRC_T2_CH2 = 5'h12, LPW_SRC_T2_CH3 = 5'h13, LPW_SRC_T2_CH4 = 5'h14,
        LPW_SRC_T2_CH5 = 5'h15
    } lpw_src_e;

    // Controller states, Gray along run, stop, recover, fetch
    typedef enum logic [2:0] {
        LPW_RUN = 3'h0,
        LPW_STOP = 3'h1,
        LPW_RECOVER = 3'h3,
        LPW_FETCH = 3'h2,
        LPW_WAIT = 3'h4
    } lpw_state_e;

    // Configuration bits
    typedef struct packed {
        logic stop_enable;
        logic short_recovery_select;
        logic osc_on_in_stop;
        logic watchdog_enable;
        logic brownout_enable;
        logic brownout_rst_enable;
        logic brownout_stop_enable;
    } lpw_cfg_s;

    // Enabled peripheral interrupt requests
    // timer1: 0 ch0, 1 ch1, 2 ovf; timer2: 0 ch0, 1 ch1, 2 ovf, 3..6 ch2..ch5
    // spi: 0 rx, 1 tx; serial: 0 err, 1 rx, 2 tx
    typedef struct packed {
        logic [2:0] timer1;
        logic [6:0] timer2;
        logic [1:0] spi;
        logic [2:0] serial;
        logic adc;
        logic tick;
        logic clock_gen;
        logic brk;
    } lpw_req_s;

    // Clock enables driven to the clock tree
    typedef struct packed {
        logic cpu_clk_en;
        logic bus_clk_en;
        logic osc_enable;
        logic loop_enable;
        logic clock_gen_out_en;
        logic watchdog_clk_en;
    } lpw_clk_s;

    // Run permissions for peripherals
    typedef struct packed {
        logic serial_active;
        logic spi_active;
        logic timer_active;
        logic tick_active;
        logic tick_reg_access;
        logic brownout_active;
    } lpw_act_s;

endpackage

// ---- rtl/lpw_vec_rom.sv ----
// Vector pair address table with registered read data
module lpw_vec_rom
    import lpw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire lpw_src_e src,
    output logic [15:0] vector_addr
);

    // Constant table; an unknown index falls back to the reset pair
    function automatic logic [15:0] lpw_lookup(input lpw_src_e s);
        unique case (s)
            LPW_SRC_RESET: lpw_lookup = LPW_VEC_RESET;
            LPW_SRC_BREAK: lpw_lookup = LPW_VEC_BREAK;
            LPW_SRC_EXT_IRQ: lpw_lookup = LPW_VEC_EXT_IRQ;
            LPW_SRC_CLOCK_GEN: lpw_lookup = LPW_VEC_CLOCK_GEN;
            LPW_SRC_T1_CH0: lpw_lookup = LPW_VEC_T1_CH0;
            LPW_SRC_T1_CH1: lpw_lookup = LPW_VEC_T1_CH1;
            LPW_SRC_T1_OVF: lpw_lookup = LPW_VEC_T1_OVF;
            LPW_SRC_T2_CH0: lpw_lookup = LPW_VEC_T2_CH0;
            LPW_SRC_T2_CH1: lpw_lookup = LPW_VEC_T2_CH1;
            LPW_SRC_T2_OVF: lpw_lookup = LPW_VEC_T2_OVF;
            LPW_SRC_SPI_RX: lpw_lookup = LPW_VEC_SPI_RX;
            LPW_SRC_SPI_TX: lpw_lookup = LPW_VEC_SPI_TX;
            LPW_SRC_SER_ERR: lpw_lookup = LPW_VEC_SER_ERR;
            LPW_SRC_SER_RX: lpw_lookup = LPW_VEC_SER_RX;
            LPW_SRC_SER_TX: lpw_lookup = LPW_VEC_SER_TX;
            LPW_SRC_KEY: lpw_lookup = LPW_VEC_KEY;
            LPW_SRC_ADC: lpw_lookup = LPW_VEC_ADC;
            LPW_SRC_TICK: lpw_lookup = LPW_VEC_TICK;
            LPW_SRC_T2_CH2: lpw_lookup = LPW_VEC_T2_CH2;
            LPW_SRC_T2_CH3: lpw_lookup = LPW_VEC_T2_CH3;
            LPW_SRC_T2_CH4: lpw_lookup = LPW_VEC_T2_CH4;
            LPW_SRC_T2_CH5: lpw_lookup = LPW_VEC_T2_CH5;
            default: lpw_lookup = LPW_VEC_RESET;
        endcase
    endfunction

    // Registered read, one cycle behind the index
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_addr <= LPW_VEC_RESET;
        end else begin
            vector_addr <= lpw_lookup(src);
        end
    end

endmodule
